// *** hdl/cfe_pkg.sv ***
// Package for the CPU status-flag and condition-evaluation block.
// Assumes a single core clock and that the instruction sequencer drives all requests.
package cfe_pkg;

   // ------------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------------
   localparam logic [7:0] CFE_ADDR_FLAGS    = 8'hD5; // Processor flags register.
   localparam logic [7:0] CFE_ADDR_PMODE    = 8'hF1; // Port mode, write-only.
   localparam logic [7:0] CFE_ADDR_P23_LO   = 8'hFC; // First of four port 2/3 mode registers.
   localparam logic [7:0] CFE_ADDR_P23_HI   = 8'hFF; // Last of four port 2/3 mode registers.
   localparam logic [7:0] CFE_ADDR_HS0      = 8'hF4; // Handshake 0 control, write-only.
   localparam logic [7:0] CFE_ADDR_HS1      = 8'hF5; // Handshake 1 control, write-only.
   localparam logic [7:0] CFE_ADDR_SYS_BASE = 8'hC0; // First non general-purpose register.
   localparam logic [7:0] CFE_ADDR_BANKED   = 8'hE0; // First banked mode/control register.
   localparam logic [7:0] CFE_WO_READ_VAL   = 8'hFF; // Value returned by a write-only read.
   localparam logic [7:0] CFE_FLAGS_RESET   = 8'h00; // Flag register after reset.

   // ------------------------------------------------------------------
   // Flag bit positions
   // ------------------------------------------------------------------
   localparam int CFE_BIT_C   = 7;
   localparam int CFE_BIT_Z   = 6;
   localparam int CFE_BIT_S   = 5;
   localparam int CFE_BIT_V   = 4;
   localparam int CFE_BIT_D   = 3;
   localparam int CFE_BIT_H   = 2;
   localparam int CFE_BIT_QSA = 1;
   localparam int CFE_BIT_RGS = 0;
   localparam int CFE_CC_LSB  = 4; // Condition field sits in bits 7..4.
   localparam int CFE_MSB     = 7;
   localparam int CFE_NIB_MSB = 3;

   // ------------------------------------------------------------------
   // Condition codes
   // ------------------------------------------------------------------
   localparam logic [3:0] CFE_CC_NEVER  = 4'h0;
   localparam logic [3:0] CFE_CC_LT     = 4'h1;
   localparam logic [3:0] CFE_CC_LE     = 4'h2;
   localparam logic [3:0] CFE_CC_ULE    = 4'h3;
   localparam logic [3:0] CFE_CC_OV     = 4'h4;
   localparam logic [3:0] CFE_CC_MI     = 4'h5;
   localparam logic [3:0] CFE_CC_Z      = 4'h6;
   localparam logic [3:0] CFE_CC_C      = 4'h7;
   localparam logic [3:0] CFE_CC_ALWAYS = 4'h8;
   localparam logic [3:0] CFE_CC_GE     = 4'h9;
   localparam logic [3:0] CFE_CC_GT     = 4'hA;
   localparam logic [3:0] CFE_CC_UGT    = 4'hB;
   localparam logic [3:0] CFE_CC_NOV    = 4'hC;
   localparam logic [3:0] CFE_CC_PL     = 4'hD;
   localparam logic [3:0] CFE_CC_NZ     = 4'hE;
   localparam logic [3:0] CFE_CC_NC     = 4'hF;

   // Operation classes reported by the sequencer at instruction end.
   typedef enum logic [4:0] {
      CFE_OP_NONE, CFE_OP_ADD, CFE_OP_ADC, CFE_OP_SUB, CFE_OP_SBC, CFE_OP_CMP,
      CFE_OP_LOGIC, CFE_OP_BITTEST, CFE_OP_ROTATE, CFE_OP_SHIFT, CFE_OP_BCD,
      CFE_OP_CARRY_SET, CFE_OP_CARRY_CLR, CFE_OP_CARRY_INV,
      CFE_OP_GROUP0, CFE_OP_GROUP1
   } cfe_op_t;

   // One operation request from the sequencer and arithmetic unit.
   typedef struct packed {
      logic       valid;     // One-cycle strobe at the end of the instruction.
      cfe_op_t    op;        // Operation class.
      logic [7:0] opa;       // Destination operand before the operation.
      logic [7:0] opb;       // Source operand.
      logic [7:0] result;    // Result for logic, bit-test, rotate, shift and BCD ops.
      logic       shift_out; // Bit moved out by rotate/shift, carry out of BCD correction.
   } cfe_req_t;

   // Register-file access from the sequencer.
   typedef struct packed {
      logic       wr;        // Write strobe.
      logic       rd;        // Read strobe.
      logic [7:0] addr;      // Register address.
      logic [7:0] wdata;     // Write data.
   } cfe_reg_t;

   // Whole state of the block.
   typedef struct packed {
      logic [7:0] flags;     // Live flag register.
      logic [7:0] saved;     // Flags captured at interrupt entry.
      logic [7:0] rdata;     // Registered read data.
      logic       rvalid;    // Read data valid.
      logic       dst_err;   // Refused flag-register write.
   } cfe_state_t;

endpackage

// *** hdl/cfe_flag_unit.sv ***
// Status-flag register, interrupt save/restore and condition evaluation of the core.
// Assumes the sequencer strobes each finished instruction once and shares clock and reset.
//
// Operation
// - Carry set on carry or borrow past bit 7
// - Carry cleared when no carry nor borrow
// - Instructions set, clear and invert carry
// - Decimal flag set by subtract, cleared by add
// - Half-carry from bit 3 carry or borrow
// - Overflow when signed result leaves byte range
// - Logical operations always clear overflow
// - Sign flag equals result bit 7
// - Zero flag set exactly when result zero
// - Quick service flag set, cleared on return
// - Group select flag picks control bank
// - Interrupt return restores all flags but quick service
// - Flag-altering instruction cannot target flags
// - Port and handshake mode registers write-only
// - Count-down branch needs general-purpose register
// - Only carry, overflow, zero, sign testable
// - Condition field is instruction bits 7..4
// - Simple condition codes decode to single flags
// - Comparison codes decode to flag combinations
`timescale 1ns/1ps

module cfe_flag_unit
   import cfe_pkg::*;
(
   input  wire logic       core_clk,      // Core clock, 125 MHz.
   input  wire logic       resetn,        // Asynchronous reset, active low.
   input  wire cfe_req_t   req,           // Finished-instruction flag request.
   input  wire cfe_reg_t   reg_acc,       // Register-file access.
   input  wire logic       int_take,      // Interrupt entry strobe.
   input  wire logic       int_fast,      // Qualifies int_take as a fast interrupt.
   input  wire logic       service_ret,   // Interrupt return strobe.
   input  wire logic [7:0] instr,         // Conditional instruction byte.
   input  wire logic [7:0] count_reg,     // Register operand of the count-down branch.
   output logic [7:0]      flags,         // Flag register.
   output logic [7:0]      reg_rdata,     // Read data for a flag-unit read.
   output logic            reg_rvalid,    // Read data valid.
   output logic            reg_wr_err,    // Refused flag-register write.
   output logic            bank_sel,      // Active mode/control bank.
   output logic            banked_access, // Current access hits the banked area.
   output logic            cond_true,     // Condition of instr holds.
   output logic            count_reg_ok   // Count-down operand is legal.
);

   // ------------------------------------------------------------------
   // State
   // ------------------------------------------------------------------
   cfe_state_t st_q;   // Registered state.
   cfe_state_t st_d;   // Next state.

   // ------------------------------------------------------------------
   // Arithmetic flag generation
   // ------------------------------------------------------------------
   logic [8:0] sum9;     // Byte sum with carry out.
   logic [4:0] sum5;     // Low nibble sum with carry out.
   logic [8:0] dif9;     // Byte difference with borrow out.
   logic [4:0] dif5;     // Low nibble difference with borrow out.
   logic       cin;      // Carry input for add with carry.
   logic       bin;      // Borrow input for subtract with carry.
   logic       is_add;   // Operation is an addition.
   logic       is_sub;   // Operation is a subtraction or compare.
   logic       alters;   // Operation rewrites flags.
   logic [7:0] ares;     // Arithmetic result.

   // Carry in only applies to the with-carry forms.
   always_comb begin
      cin    = (req.op == CFE_OP_ADC) & st_q.flags[CFE_BIT_C];
      bin    = (req.op == CFE_OP_SBC) & st_q.flags[CFE_BIT_C];
      is_add = (req.op == CFE_OP_ADD) | (req.op == CFE_OP_ADC);
      is_sub = (req.op == CFE_OP_SUB) | (req.op == CFE_OP_SBC) | (req.op == CFE_OP_CMP);
      alters = req.valid & (req.op != CFE_OP_NONE);
      sum9   = {1'b0, req.opa} + {1'b0, req.opb} + {8'h00, cin};
      sum5   = {1'b0, req.opa[CFE_NIB_MSB:0]} + {1'b0, req.opb[CFE_NIB_MSB:0]} + {4'h0, cin};
      dif9   = {1'b0, req.opa} - {1'b0, req.opb} - {8'h00, bin};
      dif5   = {1'b0, req.opa[CFE_NIB_MSB:0]} - {1'b0, req.opb[CFE_NIB_MSB:0]} - {4'h0, bin};
      ares   = is_add ? sum9[7:0] : dif9[7:0];
   end

   // ------------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------------
   logic hit_flags;   // Access targets the flag register.
   logic hit_wo;      // Access targets a write-only mode register.

   // Port and handshake control registers are recognised only to answer reads.
   always_comb begin
      hit_flags = (reg_acc.addr == CFE_ADDR_FLAGS);
      hit_wo    = (reg_acc.addr == CFE_ADDR_PMODE) | (reg_acc.addr == CFE_ADDR_HS0) |
                  (reg_acc.addr == CFE_ADDR_HS1) |
                  ((reg_acc.addr >= CFE_ADDR_P23_LO) && (reg_acc.addr <= CFE_ADDR_P23_HI));
   end

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   // Priority, lowest to highest: register write, instruction flags,
   // interrupt entry, interrupt return. Entry and return never coincide
   // with an instruction end in a working sequencer, so the order only
   // defines what a faulty sequencer sees.
   always_comb begin
      logic [7:0] f;
      f = st_q.flags;
      st_d = st_q;
      st_d.rvalid  = 1'b0;
      st_d.dst_err = 1'b0;

      // A direct write is refused when the same instruction alters flags.
      if (reg_acc.wr && hit_flags) begin
         if (alters) begin
            st_d.dst_err = 1'b1;
         end else begin
            f = reg_acc.wdata;
         end
      end

      // Flag updates land at the end strobe; untouched bits keep their value.
      if (req.valid) begin
         case (req.op)
            CFE_OP_ADD, CFE_OP_ADC: begin
               f[CFE_BIT_C] = sum9[8];
               f[CFE_BIT_H] = sum5[4];
               f[CFE_BIT_D] = 1'b0;
               f[CFE_BIT_V] = (req.opa[CFE_MSB] == req.opb[CFE_MSB]) &
                              (ares[CFE_MSB] != req.opa[CFE_MSB]);
               f[CFE_BIT_S] = ares[CFE_MSB];
               f[CFE_BIT_Z] = (ares == 8'h00);
            end
            CFE_OP_SUB, CFE_OP_SBC: begin
               f[CFE_BIT_C] = dif9[8];
               f[CFE_BIT_H] = dif5[4];
               f[CFE_BIT_D] = 1'b1;
               f[CFE_BIT_V] = (req.opa[CFE_MSB] != req.opb[CFE_MSB]) &
                              (ares[CFE_MSB] != req.opa[CFE_MSB]);
               f[CFE_BIT_S] = ares[CFE_MSB];
               f[CFE_BIT_Z] = (ares == 8'h00);
            end
            CFE_OP_CMP: begin
               // Compare leaves the BCD flags alone since nothing is stored.
               f[CFE_BIT_C] = dif9[8];
               f[CFE_BIT_V] = (req.opa[CFE_MSB] != req.opb[CFE_MSB]) &
                              (ares[CFE_MSB] != req.opa[CFE_MSB]);
               f[CFE_BIT_S] = ares[CFE_MSB];
               f[CFE_BIT_Z] = (ares == 8'h00);
            end
            CFE_OP_LOGIC: begin
               f[CFE_BIT_V] = 1'b0;
               f[CFE_BIT_S] = req.result[CFE_MSB];
               f[CFE_BIT_Z] = (req.result == 8'h00);
            end
            CFE_OP_BITTEST: begin
               f[CFE_BIT_Z] = (req.result == 8'h00);
            end
            CFE_OP_ROTATE, CFE_OP_SHIFT: begin
               // A sign change across the shift is the signed overflow.
               f[CFE_BIT_C] = req.shift_out;
               f[CFE_BIT_V] = req.opa[CFE_MSB] ^ req.result[CFE_MSB];
               f[CFE_BIT_S] = req.result[CFE_MSB];
               f[CFE_BIT_Z] = (req.result == 8'h00);
            end
            CFE_OP_BCD: begin
               // Correction itself is done by the arithmetic unit from D and H.
               f[CFE_BIT_C] = req.shift_out;
               f[CFE_BIT_S] = req.result[CFE_MSB];
               f[CFE_BIT_Z] = (req.result == 8'h00);
            end
            CFE_OP_CARRY_SET: begin
               f[CFE_BIT_C] = 1'b1;
            end
            CFE_OP_CARRY_CLR: begin
               f[CFE_BIT_C] = 1'b0;
            end
            CFE_OP_CARRY_INV: begin
               f[CFE_BIT_C] = ~st_q.flags[CFE_BIT_C];
            end
            CFE_OP_GROUP0: begin
               f[CFE_BIT_RGS] = 1'b0;
            end
            CFE_OP_GROUP1: begin
               f[CFE_BIT_RGS] = 1'b1;
            end
            default: begin
               f = f;
            end
         endcase
      end

      // Interrupt entry saves the byte that will come back on return.
      if (int_take) begin
         st_d.saved = f;
         if (int_fast) begin
            f[CFE_BIT_QSA] = 1'b1;
         end
      end

      // Return brings back every bit but quick service, which it clears to end any fast service.
      if (service_ret) begin
         f = st_q.saved;
         f[CFE_BIT_QSA] = 1'b0;
      end

      st_d.flags = f;

      // Reads of write-only registers never expose their settings.
      if (reg_acc.rd && hit_flags) begin
         st_d.rdata  = st_q.flags;
         st_d.rvalid = 1'b1;
      end else if (reg_acc.rd && hit_wo) begin
         st_d.rdata  = CFE_WO_READ_VAL;
         st_d.rvalid = 1'b1;
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   // All state clears to constants, so flags are defined from reset.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         st_q.flags   <= CFE_FLAGS_RESET;
         st_q.saved   <= CFE_FLAGS_RESET;
         st_q.rdata   <= 8'h00;
         st_q.rvalid  <= 1'b0;
         st_q.dst_err <= 1'b0;
      end else begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------------
   // Condition evaluation
   // ------------------------------------------------------------------
   logic [3:0] cc;    // Condition field of the instruction.
   logic       fc;    // Carry.
   logic       fz;    // Zero.
   logic       fs;    // Sign.
   logic       fv;    // Overflow.

   // Only C, Z, S and V feed the decoder; H and D are never looked at.
   always_comb begin
      cc = instr[CFE_MSB:CFE_CC_LSB];
      fc = st_q.flags[CFE_BIT_C];
      fz = st_q.flags[CFE_BIT_Z];
      fs = st_q.flags[CFE_BIT_S];
      fv = st_q.flags[CFE_BIT_V];
      case (cc)
         CFE_CC_NEVER:  cond_true = 1'b0;
         CFE_CC_ALWAYS: cond_true = 1'b1;
         CFE_CC_C:      cond_true = fc;
         CFE_CC_NC:     cond_true = ~fc;
         CFE_CC_Z:      cond_true = fz;
         CFE_CC_NZ:     cond_true = ~fz;
         CFE_CC_MI:     cond_true = fs;
         CFE_CC_PL:     cond_true = ~fs;
         CFE_CC_OV:     cond_true = fv;
         CFE_CC_NOV:    cond_true = ~fv;
         CFE_CC_GE:     cond_true = ~(fs ^ fv);
         CFE_CC_LT:     cond_true = fs ^ fv;
         CFE_CC_GT:     cond_true = ~(fz | (fs ^ fv));
         CFE_CC_LE:     cond_true = fz | (fs ^ fv);
         CFE_CC_UGT:    cond_true = ~fc & ~fz;
         CFE_CC_ULE:    cond_true = fc | fz;
         default:       cond_true = 1'b0;
      endcase
   end

   // ------------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------------
   // Bank steering follows the registered flag, so a group change takes
   // effect on the access after the instruction that made it.
   assign flags         = st_q.flags;
   assign reg_rdata     = st_q.rdata;
   assign reg_rvalid    = st_q.rvalid;
   assign reg_wr_err    = st_q.dst_err;
   assign bank_sel      = st_q.flags[CFE_BIT_RGS];
   assign banked_access = (reg_acc.addr >= CFE_ADDR_BANKED);
   assign count_reg_ok  = (count_reg < CFE_ADDR_SYS_BASE);

endmodule

// *** tb/cfe_flag_unit_chk.sv ***
// Port checker of the flag unit, bound to every instance.
// Assumes one core clock and an active-low asynchronous reset.
`timescale 1ns/1ps

module cfe_flag_unit_chk
   import cfe_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       resetn,
   input wire cfe_req_t   req,
   input wire cfe_reg_t   reg_acc,
   input wire logic       int_take,
   input wire logic       int_fast,
   input wire logic       service_ret,
   input wire logic [7:0] instr,
   input wire logic [7:0] count_reg,
   input wire logic [7:0] flags,
   input wire logic [7:0] reg_rdata,
   input wire logic       reg_rvalid,
   input wire logic       reg_wr_err,
   input wire logic       bank_sel,
   input wire logic       banked_access,
   input wire logic       cond_true,
   input wire logic       count_reg_ok
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);

   // --------------------------------------------------------------
   // Helpers
   // --------------------------------------------------------------
   logic [8:0] sum9;  // Nine-bit sum of the operands.
   logic [8:0] dif9;  // Nine-bit difference, borrow in bit 8.
   logic       c_now; // Present carry flag.
   logic       go;    // A request that no return overrides.
   logic       wo;    // Access hits a write-only register.
   assign sum9  = {1'b0, req.opa} + {1'b0, req.opb};
   assign dif9  = {1'b0, req.opa} - {1'b0, req.opb};
   assign c_now = flags[CFE_BIT_C];
   assign go    = req.valid && !service_ret;
   assign wo    = reg_acc.addr inside {CFE_ADDR_PMODE, CFE_ADDR_HS0, CFE_ADDR_HS1} || reg_acc.addr >= CFE_ADDR_P23_LO;

   // --------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------
   a_add_carry: assert property (go && req.op == CFE_OP_ADD |=> c_now == $past(sum9[8]) && !flags[CFE_BIT_D])
      else $error("add C or D wrong");
   a_sub_borrow: assert property (go && req.op == CFE_OP_SUB |=> c_now == $past(dif9[8]) && flags[CFE_BIT_D])
      else $error("sub C or D wrong");
   a_logic_flags: assert property (go && req.op == CFE_OP_LOGIC |=> !flags[CFE_BIT_V] && flags[CFE_BIT_Z] == ($past(req.result) == 8'h00))
      else $error("logic op V or Z wrong");
   a_carry_inv: assert property (go && req.op == CFE_OP_CARRY_INV |=> c_now != $past(c_now))
      else $error("carry not inverted");
   a_group_only: assert property (go && req.op == CFE_OP_GROUP1 && !reg_acc.wr && !int_take |=> flags == ($past(flags) | 8'h01))
      else $error("group op changed other flags");
   a_fast_flag: assert property (int_take && int_fast && !service_ret |=> flags[CFE_BIT_QSA])
      else $error("fast flag not set");
   a_ret_clear: assert property (service_ret |=> !flags[CFE_BIT_QSA])
      else $error("fast flag kept after return");
   a_wo_read: assert property (reg_acc.rd && wo |=> reg_rvalid && reg_rdata == CFE_WO_READ_VAL)
      else $error("write-only read exposed");
   a_dst_refuse: assert property (reg_acc.wr && reg_acc.addr == CFE_ADDR_FLAGS && go && req.op != CFE_OP_NONE |=> reg_wr_err)
      else $error("flag write not refused");
   a_bank_follow: assert property (bank_sel == flags[CFE_BIT_RGS] && banked_access == (reg_acc.addr >= CFE_ADDR_BANKED))
      else $error("bank decode wrong");
   a_cc_carry: assert property (instr[7:4] == CFE_CC_NC |-> cond_true == !c_now)
      else $error("no-carry condition wrong");
   a_cc_never: assert property (instr[7:4] == CFE_CC_NEVER |-> !cond_true)
      else $error("never condition true");
   a_count_ok: assert property (count_reg_ok == (count_reg < CFE_ADDR_SYS_BASE))
      else $error("count operand legality wrong");

   c_refuse: cover property (reg_wr_err);
   c_ret: cover property (int_take ##[1:20] service_ret);
   c_wo: cover property (reg_acc.rd && wo);
endmodule

bind cfe_flag_unit cfe_flag_unit_chk u_chk (
   .core_clk(core_clk), .resetn(resetn), .req(req), .reg_acc(reg_acc), .int_take(int_take),
   .int_fast(int_fast), .service_ret(service_ret), .instr(instr), .count_reg(count_reg),
   .flags(flags), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_wr_err(reg_wr_err),
   .bank_sel(bank_sel), .banked_access(banked_access), .cond_true(cond_true), .count_reg_ok(count_reg_ok));

// *** tb/cfe_alu_model.sv ***
// Arithmetic-unit stand-in: result and shifted-out bit per operation.
// Assumes the bench drives the operation class and both operands.
`timescale 1ns/1ps

module cfe_alu_model
   import cfe_pkg::*;
(
   input  wire cfe_op_t    op,
   input  wire logic [7:0] opa,
   input  wire logic [7:0] opb,
   output logic [7:0]      result,
   output logic            shift_out
);
   // Rotate left, shift right arithmetic: both byte ends get used.
   always_comb begin
      shift_out = 1'b0;
      case (op)
         CFE_OP_ADD:                   result = opa + opb;
         CFE_OP_SUB, CFE_OP_CMP:       result = opa - opb;
         CFE_OP_LOGIC, CFE_OP_BITTEST: result = opa & opb;
         CFE_OP_ROTATE: begin
            result    = {opa[6:0], opa[7]};
            shift_out = opa[7];
         end
         CFE_OP_SHIFT: begin
            result    = {opa[7], opa[7:1]};
            shift_out = opa[0];
         end
         default:                      result = opa;
      endcase
   end
endmodule

// *** tb/cfe_flag_unit_tb.sv ***
// Self-checking flag-unit bench: drivers queue expectations, monitors compare.
// Assumes the arithmetic-unit model and bound checker are compiled too.
`timescale 1ns/1ps

module cfe_flag_unit_tb
   import cfe_pkg::*;
;
   logic       core_clk = 1'b0;
   logic       resetn = 1'b0;
   logic       req_v = 1'b0;
   cfe_op_t    req_op = CFE_OP_NONE;
   logic [7:0] req_a = 8'h00;
   logic [7:0] req_b = 8'h00;
   logic [7:0] res;
   logic       so;
   cfe_req_t   req;
   cfe_reg_t   acc = '0;
   logic       int_take = 1'b0;
   logic       int_fast = 1'b0;
   logic       ret = 1'b0;
   logic [7:0] instr = 8'h00;
   logic [7:0] cnt = 8'h00;
   logic [7:0] flags, rdata, ef = 8'h00, sv = 8'h00;
   logic       rvalid, wr_err, bank_sel, banked, cond_true, cnt_ok, upd = 1'b0;
   logic [7:0] q_f[$], q_r[$];
   int         n_mismatch = 0, checks = 0, cyc_n = 0;
   assign req = '{req_v, req_op, req_a, req_b, res, so};

   always #4 core_clk = !core_clk;
   cfe_alu_model alu (.op(req_op), .opa(req_a), .opb(req_b), .result(res), .shift_out(so));
   cfe_flag_unit dut (.core_clk(core_clk), .resetn(resetn), .req(req), .reg_acc(acc), .int_take(int_take),
      .int_fast(int_fast), .service_ret(ret), .instr(instr), .count_reg(cnt), .flags(flags), .reg_rdata(rdata),
      .reg_rvalid(rvalid), .reg_wr_err(wr_err), .bank_sel(bank_sel), .banked_access(banked),
      .cond_true(cond_true), .count_reg_ok(cnt_ok));

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      if (n_mismatch == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Next flag byte, from the rules alone.
   function automatic logic [7:0] nf(cfe_op_t o, logic [7:0] a, logic [7:0] b, logic [7:0] r, logic s, logic [7:0] f);
      logic [4:0] h;
      logic       sb;
      sb = (o != CFE_OP_ADD);
      h = sb ? {1'b0, a[3:0]} - {1'b0, b[3:0]} : {1'b0, a[3:0]} + {1'b0, b[3:0]};
      if (o inside {CFE_OP_ADD, CFE_OP_SUB, CFE_OP_CMP}) begin
         f[7] = sb ? (a < b) : (9'(a) + 9'(b) > 9'h0FF);
         f[4] = ((a[7] ^ b[7]) == sb) && (r[7] != a[7]);
         if (o != CFE_OP_CMP) begin
            f[3] = sb;
            f[2] = h[4];
         end
      end
      if (o inside {CFE_OP_ROTATE, CFE_OP_SHIFT, CFE_OP_BCD}) f[7] = s;
      if (o inside {CFE_OP_ROTATE, CFE_OP_SHIFT}) f[4] = a[7] ^ r[7];
      if (o == CFE_OP_LOGIC) f[4] = 1'b0;
      if (o inside {CFE_OP_ADD, CFE_OP_SUB, CFE_OP_CMP, CFE_OP_LOGIC, CFE_OP_ROTATE, CFE_OP_SHIFT, CFE_OP_BCD,
                    CFE_OP_BITTEST}) begin
         f[6] = (r == 8'h00);
         if (o != CFE_OP_BITTEST) f[5] = r[7];
      end
      case (o)
         CFE_OP_CARRY_SET: f[7] = 1'b1;
         CFE_OP_CARRY_CLR: f[7] = 1'b0;
         CFE_OP_CARRY_INV: f[7] = !f[7];
         CFE_OP_GROUP0:    f[0] = 1'b0;
         CFE_OP_GROUP1:    f[0] = 1'b1;
         default: ;
      endcase
      return f;
   endfunction

   // Condition decode: low three bits pick a test, bit 3 inverts it.
   function automatic logic cx(logic [3:0] c, logic [7:0] f);
      logic [7:0] t;
      t = {f[7], f[6], f[5], f[4], f[7] | f[6], f[6] | (f[5] ^ f[4]), f[5] ^ f[4], 1'b0};
      return t[c[2:0]] ^ c[3];
   endfunction

   // One clock of stimulus, then its expectation is queued.
   task automatic cyc(logic v, cfe_op_t o, logic [7:0] a, logic [7:0] b, cfe_reg_t r, logic [1:0] tk, logic rt);
      logic [7:0] e0;
      #1;
      {req_v, req_op, req_a, req_b, acc, int_fast, int_take, ret} = {v, o, a, b, r, tk, rt};
      e0 = ef;
      @(posedge core_clk);
      if (rt) ef = sv & 8'hFD;
      else begin
         if (v && o != CFE_OP_NONE) ef = nf(o, a, b, res, so, ef);
         else if (r.wr && r.addr == CFE_ADDR_FLAGS) ef = r.wdata;
         if (tk[0]) sv = ef;
         if (tk == 2'h3) ef[1] = 1'b1;
      end
      if (rt || tk[0] || (v && o != CFE_OP_NONE) || (r.wr && r.addr == CFE_ADDR_FLAGS)) q_f.push_back(ef);
      if (r.rd && r.addr == CFE_ADDR_FLAGS) q_r.push_back(e0);
      if (r.rd && (r.addr inside {CFE_ADDR_PMODE, CFE_ADDR_HS0, CFE_ADDR_HS1} || r.addr >= CFE_ADDR_P23_LO))
         q_r.push_back(CFE_WO_READ_VAL);
   endtask

   task automatic op(cfe_op_t o, logic [7:0] a, logic [7:0] b);
      cyc(1'b1, o, a, b, '0, 2'h0, 1'b0);
   endtask

   task automatic rg(logic w, logic rd, logic [7:0] ad, logic [7:0] d);
      cyc(1'b0, CFE_OP_NONE, 8'h00, 8'h00, '{w, rd, ad, d}, 2'h0, 1'b0);
   endtask

   // Monitors: flags a cycle after a request, read data on its valid.
   always @(posedge core_clk) begin
      upd <= ret || int_take || (req_v && req_op != CFE_OP_NONE) || (acc.wr && acc.addr == CFE_ADDR_FLAGS);
      cyc_n++;
      if (cyc_n == 3000) begin
         n_mismatch++;
         conclude();
      end
   end
   always @(negedge core_clk) begin
      if (upd) check(flags, q_f.size() ? q_f.pop_front() : 8'hXX);
      if (rvalid) check(rdata, q_r.size() ? q_r.pop_front() : 8'hXX);
   end

   initial begin
      cfe_op_t    ops[] = '{CFE_OP_CARRY_SET, CFE_OP_CARRY_INV, CFE_OP_CARRY_CLR, CFE_OP_CARRY_INV, CFE_OP_GROUP1,
                           CFE_OP_BCD, CFE_OP_SHIFT, CFE_OP_CMP, CFE_OP_GROUP0, CFE_OP_NONE};
      logic [7:0] ads[] = '{8'hF1, 8'hF4, 8'hF5, 8'hFC, 8'hFD, 8'hFE, 8'hFF, 8'hD5, 8'h10, 8'hE0};
      void'($urandom(35834));
      repeat (12) @(posedge core_clk);
      #1 resetn = 1'b1;
      @(posedge core_clk);
      check(flags, CFE_FLAGS_RESET);
      op(CFE_OP_ADD, 8'h7F, 8'h01);
      op(CFE_OP_ADD, 8'hFF, 8'h01);
      op(CFE_OP_SUB, 8'h80, 8'h01);
      repeat (24) op(($urandom & 1) ? CFE_OP_SUB : CFE_OP_ADD, 8'($urandom), 8'($urandom));
      op(CFE_OP_LOGIC, 8'hF0, 8'h0F);
      op(CFE_OP_ROTATE, 8'h81, 8'h00);
      op(CFE_OP_ROTATE, 8'h40, 8'h00);
      op(CFE_OP_BITTEST, 8'($urandom), 8'h08);
      foreach (ops[i]) op(ops[i], 8'($urandom), 8'($urandom));
      rg(1'b0, 1'b1, CFE_ADDR_FLAGS, 8'h00);
      rg(1'b1, 1'b0, CFE_ADDR_FLAGS, 8'hA5);
      cyc(1'b0, CFE_OP_NONE, 8'h00, 8'h00, '0, 2'h3, 1'b0);
      op(CFE_OP_ADD, 8'h80, 8'h80);
      cyc(1'b0, CFE_OP_NONE, 8'h00, 8'h00, '0, 2'h0, 1'b1);
      cyc(1'b1, CFE_OP_SUB, 8'h12, 8'h34, '0, 2'h1, 1'b0);
      cyc(1'b1, CFE_OP_ADD, 8'h01, 8'h01, '{1'b1, 1'b0, CFE_ADDR_FLAGS, 8'h55}, 2'h0, 1'b0);
      cyc(1'b1, CFE_OP_LOGIC, 8'h01, 8'h01, '0, 2'h0, 1'b1);
      foreach (ads[i]) rg(1'b0, 1'b1, ads[i], 8'h00);
      rg(1'b1, 1'b0, CFE_ADDR_PMODE, 8'h00);
      repeat (6) begin
         rg(1'b1, 1'b0, CFE_ADDR_FLAGS, 8'($urandom));
         #1 acc = '0;
         for (int c = 0; c < 16; c++) begin
            @(posedge core_clk);
            #1 instr = {4'(c), 4'($urandom)};
            cnt = 8'($urandom);
            #1 check(cond_true, cx(4'(c), ef));
            check(cnt_ok, cnt < CFE_ADDR_SYS_BASE);
            check(bank_sel, ef[0]);
         end
      end
      repeat (3) rg(1'b0, 1'b0, 8'h00, 8'h00);
      check(8'(q_f.size() + q_r.size()), 8'h00);
      conclude();
   end
endmodule
